/* File: src/hss_consts.vh */
// register indices, field positions, codes and reset values
// for the two-channel hdlc status block; included by bare name
`ifndef HSS_CONSTS_VH
`define HSS_CONSTS_VH

// register indices; byte address is four times the index
`define HSS_IDX_STAT0 8'hCB
`define HSS_IDX_STAT1 8'hD3
`define HSS_IDX_RXDATA0 8'hC8
`define HSS_IDX_TXDATA0 8'hC9
`define HSS_IDX_RXDATA1 8'hD0
`define HSS_IDX_TXDATA1 8'hD1
`define HSS_IDX_GAP 8'hE8
`define HSS_IDX_INTSTAT 8'hF0
`define HSS_IDX_INTMASK 8'hF1

// channel status byte layout
`define HSS_ST_RXFULL 7
`define HSS_ST_TAGHI 6
`define HSS_ST_OVR 5
`define HSS_ST_TAGLO 4
`define HSS_ST_TXFULL 3
`define HSS_ST_CAUSEHI 2
`define HSS_ST_CAUSELO 1
`define HSS_ST_SHORT 0

// transmit data register: bit 8 marks the frame's final byte
`define HSS_TX_LAST 8

// receive tag codes
`define HSS_TAG_DATA 2'h0
`define HSS_TAG_ABORT 2'h1
`define HSS_TAG_GOOD 2'h2
`define HSS_TAG_BAD 2'h3

// transmit interrupt cause codes
`define HSS_CAUSE_EMPTY 2'h0
`define HSS_CAUSE_CRC 2'h1
`define HSS_CAUSE_ABORT 2'h2
`define HSS_CAUSE_CLOSE 2'h3

// flags between frames
`define HSS_GAP_ONE 2'h1
`define HSS_GAP_TWO 2'h2

// interrupt status bit bases (plus channel number)
`define HSS_INT_RX 0
`define HSS_INT_OVR 2
`define HSS_INT_TX 4
`define HSS_INT_END 6

// reset values
`define HSS_RST_MASK 8'h00
`define HSS_RST_GAP 2'h2

`endif

/* File: src/hss_rx_chan.v */
// one-entry receive buffer of one channel with its tag and overrun
// assumes the frame engine pulses inValid once per received byte
`timescale 1ns/1ps
`include "hss_consts.vh"

module hss_rx_chan (
  // clock and reset
  input wire ref_clk,
  input wire rst_n,
  // from the frame engine
  input wire inValid,
  input wire [7:0] inData,
  input wire [1:0] inTag,
  input wire inShort,
  // from the bus: the buffer is read
  input wire pop,
  // buffer head and its status
  output reg full,
  output reg [7:0] data,
  output reg [1:0] tag,
  output reg short,
  output reg overrun
);

  // head entry: load on arrival, empty on read
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      full <= 1'b0;
      data <= 8'h00;
      tag <= `HSS_TAG_DATA;
      short <= 1'b0;
      overrun <= 1'b0;
    end else begin
      if (inValid && (!full || pop)) begin
        full <= 1'b1;
        data <= inData;
        tag <= inTag;
        short <= inShort;
      end else if (pop) begin
        full <= 1'b0;
        tag <= `HSS_TAG_DATA;
        short <= 1'b0;
      end
      // new byte dropped when head not read; a read in the same cycle takes the byte and clears overrun
      if (inValid && full && !pop) begin
        overrun <= 1'b1;
      end else if (pop) begin
        overrun <= 1'b0;
      end
    end
  end

endmodule

/* File: src/hss_tx_chan.v */
// transmit buffer, interrupt cause and flag spacing of one channel
// assumes the engine pulses take only while full, and one done at a time
`timescale 1ns/1ps
`include "hss_consts.vh"

module hss_tx_chan (
  // clock and reset
  input wire ref_clk,
  input wire rst_n,
  // from the bus
  input wire wrData,
  input wire [7:0] wrByte,
  input wire wrLast,
  input wire wrStat,
  // from the frame engine
  input wire take,
  input wire crcDone,
  input wire abortDone,
  input wire closeDone,
  // buffer and interrupt state
  output reg full,
  output reg [7:0] byteOut,
  output reg last,
  output reg pending,
  output reg [1:0] cause,
  output reg [1:0] gap
);

  reg skipClose;

  // buffer, pending cause and flag count
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      full <= 1'b0;
      byteOut <= 8'h00;
      last <= 1'b0;
      pending <= 1'b0;
      cause <= `HSS_CAUSE_EMPTY;
      gap <= `HSS_RST_GAP;
      skipClose <= 1'b0;
    end else begin
      if (wrData) begin
        full <= 1'b1;
        byteOut <= wrByte;
        last <= wrLast;
        if (pending && cause == `HSS_CAUSE_CRC) begin
          gap <= `HSS_GAP_ONE;
          skipClose <= 1'b1;
        end else begin
          gap <= `HSS_GAP_TWO;
        end
      end else if (take) begin
        full <= 1'b0;
      end
      if (closeDone) begin
        skipClose <= 1'b0;
      end
      // events win over the clear in the same cycle
      if (take && !last) begin
        pending <= 1'b1;
        cause <= `HSS_CAUSE_EMPTY;
      end else if (crcDone) begin
        pending <= 1'b1;
        cause <= `HSS_CAUSE_CRC;
      end else if (abortDone) begin
        pending <= 1'b1;
        cause <= `HSS_CAUSE_ABORT;
      end else if (closeDone && !skipClose) begin
        pending <= 1'b1;
        cause <= `HSS_CAUSE_CLOSE;
      end else if (wrData || wrStat) begin
        pending <= 1'b0;
      end
    end
  end

endmodule

/* File: src/hss_status.v */
// two-channel hdlc status block with an avalon-mm register slave
// assumes a frame engine per channel on the serial side, synchronous
// to ref_clk, and a bus master that holds requests through waitrequest
//
// How it works
// - byte buffered sets receive-full, requests interrupt
// - empty receive buffer withdraws receive request
// - bits 6,4 tag byte data/abort/good/bad
// - overrun set on overflow, cleared by read
// - transmitter takes non-final byte, interrupt requested
// - tx buffer or status write clears interrupt
// - cause 00 means transmit buffer empty
// - crc sent raises interrupt, cause 01
// - reply to crc interrupt: one flag, silent
// - abort finished raises interrupt, cause 10
// - closing flag cause 11, reply gets two flags
// - bit 0 marks short received byte
//
// Our own choice: the Avalon-MM slave port.
`timescale 1ns/1ps
`include "hss_consts.vh"

module hss_status (
  // clock and reset
  input wire ref_clk,
  input wire rst_n,
  // avalon-mm slave, word addressed
  input wire [7:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  // receive side of the frame engines, one lane per channel
  input wire [1:0] rxValid,
  input wire [15:0] rxData,
  input wire [3:0] rxTag,
  input wire [1:0] rxShort,
  // transmit side of the frame engines
  input wire [1:0] txTake,
  input wire [1:0] txCrcDone,
  input wire [1:0] txAbortDone,
  input wire [1:0] txCloseDone,
  output wire [15:0] txData,
  output wire [1:0] txLast,
  output wire [1:0] txFull,
  output wire [3:0] flagGap,
  // interrupt requests
  output reg [1:0] chanIrq,
  output reg irq
);

  // bus handshake state
  wire busReq;
  wire busTake;
  wire rdTake;
  wire wrTake;

  // per-channel decoded strobes
  wire [1:0] popRx;
  wire [1:0] wrTx;
  wire [1:0] wrStat;

  // per-channel state from the channel modules
  wire [1:0] rxFull;
  wire [15:0] rxHead;
  wire [3:0] rxHeadTag;
  wire [1:0] rxHeadShort;
  wire [1:0] rxOverrun;
  wire [1:0] txPend;
  wire [3:0] txCause;
  wire [15:0] statByte;

  // interrupt bookkeeping
  reg [7:0] intStat;
  reg [7:0] intMask;
  reg [1:0] ovrPrev;
  reg [1:0] pendPrev;
  reg [7:0] next_intStat;
  wire [7:0] intEvent;
  wire intStatRead;

  // read data mux
  reg [31:0] next_readdata;

  // a request is taken on the edge where waitrequest is low
  assign busReq = avs_read || avs_write;
  assign busTake = busReq && !avs_waitrequest;
  assign rdTake = avs_read && !avs_waitrequest;
  assign wrTake = avs_write && !avs_waitrequest;

  // one wait state: low for one cycle after the request is seen
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      avs_waitrequest <= 1'b1;
    end else if (busReq && avs_waitrequest) begin
      avs_waitrequest <= 1'b0;
    end else begin
      avs_waitrequest <= 1'b1;
    end
  end

  // strobes that hit each channel
  assign popRx[0] = rdTake && (avs_address == `HSS_IDX_RXDATA0);
  assign popRx[1] = rdTake && (avs_address == `HSS_IDX_RXDATA1);
  assign wrTx[0] = wrTake && (avs_address == `HSS_IDX_TXDATA0);
  assign wrTx[1] = wrTake && (avs_address == `HSS_IDX_TXDATA1);
  assign wrStat[0] = wrTake && (avs_address == `HSS_IDX_STAT0);
  assign wrStat[1] = wrTake && (avs_address == `HSS_IDX_STAT1);

  // one receive and one transmit engine front per channel
  genvar ch;
  generate
    for (ch = 0; ch < 2; ch = ch + 1) begin : gChan
      hss_rx_chan uRx (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .inValid(rxValid[ch]),
        .inData(rxData[ch*8 +: 8]),
        .inTag(rxTag[ch*2 +: 2]),
        .inShort(rxShort[ch]),
        .pop(popRx[ch]),
        .full(rxFull[ch]),
        .data(rxHead[ch*8 +: 8]),
        .tag(rxHeadTag[ch*2 +: 2]),
        .short(rxHeadShort[ch]),
        .overrun(rxOverrun[ch])
      );

      hss_tx_chan uTx (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .wrData(wrTx[ch]),
        .wrByte(avs_writedata[7:0]),
        .wrLast(avs_writedata[`HSS_TX_LAST]),
        .wrStat(wrStat[ch]),
        .take(txTake[ch]),
        .crcDone(txCrcDone[ch]),
        .abortDone(txAbortDone[ch]),
        .closeDone(txCloseDone[ch]),
        .full(txFull[ch]),
        .byteOut(txData[ch*8 +: 8]),
        .last(txLast[ch]),
        .pending(txPend[ch]),
        .cause(txCause[ch*2 +: 2]),
        .gap(flagGap[ch*2 +: 2])
      );

      // channel status byte; the written value of a status write is dropped
      assign statByte[ch*8 + `HSS_ST_RXFULL] = rxFull[ch];
      assign statByte[ch*8 + `HSS_ST_TAGHI] = rxHeadTag[ch*2 + 1];
      assign statByte[ch*8 + `HSS_ST_OVR] = rxOverrun[ch];
      assign statByte[ch*8 + `HSS_ST_TAGLO] = rxHeadTag[ch*2];
      assign statByte[ch*8 + `HSS_ST_TXFULL] = txFull[ch];
      assign statByte[ch*8 + `HSS_ST_CAUSEHI] = txCause[ch*2 + 1];
      assign statByte[ch*8 + `HSS_ST_CAUSELO] = txCause[ch*2];
      assign statByte[ch*8 + `HSS_ST_SHORT] = rxHeadShort[ch];

      // events: byte arrived, overrun began, transmit request rose, frame ended
      assign intEvent[`HSS_INT_RX + ch] = rxValid[ch];
      assign intEvent[`HSS_INT_OVR + ch] = rxOverrun[ch] && !ovrPrev[ch];
      assign intEvent[`HSS_INT_TX + ch] = txPend[ch] && !pendPrev[ch];
      assign intEvent[`HSS_INT_END + ch] = rxValid[ch] && rxTag[ch*2 + 1];
    end
  endgenerate

  // edge history for the level flags
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      ovrPrev <= 2'h0;
      pendPrev <= 2'h0;
    end else begin
      ovrPrev <= rxOverrun;
      pendPrev <= txPend;
    end
  end

  // sticky status: a read clears, an event in the same cycle survives
  assign intStatRead = rdTake && (avs_address == `HSS_IDX_INTSTAT);

  always @* begin
    if (intStatRead) begin
      next_intStat = intEvent;
    end else begin
      next_intStat = intStat | intEvent;
    end
  end

  // sticky status and mask registers
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      intStat <= 8'h00;
      intMask <= `HSS_RST_MASK;
    end else begin
      intStat <= next_intStat;
      if (wrTake && (avs_address == `HSS_IDX_INTMASK)) begin
        intMask <= avs_writedata[7:0];
      end
    end
  end

  // interrupt outputs: per-channel serial request and masked summary
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      chanIrq <= 2'h0;
      irq <= 1'b0;
    end else begin
      chanIrq <= rxFull | txPend;
      irq <= |(next_intStat & intMask);
    end
  end

  // read decode; unmapped indices read zero
  always @* begin
    next_readdata = 32'h00000000;
    if (avs_address == `HSS_IDX_STAT0) begin
      next_readdata[7:0] = statByte[7:0];
    end else if (avs_address == `HSS_IDX_STAT1) begin
      next_readdata[7:0] = statByte[15:8];
    end else if (avs_address == `HSS_IDX_RXDATA0) begin
      next_readdata[7:0] = rxHead[7:0];
    end else if (avs_address == `HSS_IDX_RXDATA1) begin
      next_readdata[7:0] = rxHead[15:8];
    end else if (avs_address == `HSS_IDX_TXDATA0) begin
      next_readdata[7:0] = txData[7:0];
      next_readdata[`HSS_TX_LAST] = txLast[0];
    end else if (avs_address == `HSS_IDX_TXDATA1) begin
      next_readdata[7:0] = txData[15:8];
      next_readdata[`HSS_TX_LAST] = txLast[1];
    end else if (avs_address == `HSS_IDX_GAP) begin
      next_readdata[3:0] = flagGap;
    end else if (avs_address == `HSS_IDX_INTSTAT) begin
      next_readdata[7:0] = intStat;
    end else if (avs_address == `HSS_IDX_INTMASK) begin
      next_readdata[7:0] = intMask;
    end
  end

  // read data stands in the cycle waitrequest is low
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      avs_readdata <= 32'h00000000;
    end else if (avs_read && avs_waitrequest) begin
      avs_readdata <= next_readdata;
    end else begin
      avs_readdata <= 32'h00000000;
    end
  end

endmodule

/* File: verif/hss_checker.sv */
// assertions on the ports of the two-channel status block, channel 0
// assumes bind from tb; single ref_clk domain, rst_n synchronous low
`timescale 1ns/1ps
`include "hss_consts.vh"
module hss_checker (
  // clock and reset
  input wire ref_clk,
  input wire rst_n,
  // register bus
  input wire [7:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [31:0] avs_readdata,
  input wire avs_waitrequest,
  // engine side and interrupts
  input wire [1:0] rxValid,
  input wire [1:0] txTake,
  input wire [1:0] txCrcDone,
  input wire [1:0] txAbortDone,
  input wire [15:0] txData,
  input wire [1:0] txLast,
  input wire [1:0] txFull,
  input wire [1:0] chanIrq
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // transmit data write taken on this edge
  wire wrTx = avs_write && !avs_waitrequest && avs_address == `HSS_IDX_TXDATA0;
  // channel request two cycles after its cause
  sequence late_irq;
    ##2 chanIrq[0];
  endsequence
  rx_irq_a: assert property (rxValid[0] |-> late_irq)
    else $error("byte arrival raised no request");
  take_irq_a: assert property (txTake[0] && !txLast[0] && !wrTx |-> late_irq)
    else $error("take of plain byte raised no request");
  crc_irq_a: assert property (txCrcDone[0] |-> late_irq)
    else $error("crc end raised no request");
  abort_irq_a: assert property (txAbortDone[0] |-> late_irq)
    else $error("abort end raised no request");
  tx_load_a: assert property (wrTx |=> txFull[0] && txData[7:0] == $past(avs_writedata[7:0])
    && txLast[0] == $past(avs_writedata[8]))
    else $error("transmit write not buffered");
  tx_empty_a: assert property (txTake[0] && !wrTx |=> !txFull[0])
    else $error("take left buffer occupied");
  one_wait_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus answer late");
  idle_zero_a: assert property (!(avs_read && !avs_waitrequest) |-> avs_readdata == 32'h0)
    else $error("read data not zero when idle");
endmodule

/* File: verif/hss_eng_model.sv */
// frame engine stand-in for both channels, driven through its tasks
// assumes callers sit on a ref_clk edge; pulses last one cycle
`timescale 1ns/1ps
module hss_eng_model (
  // clock
  input wire ref_clk,
  // receive lanes
  output logic [1:0] rxValid,
  output logic [15:0] rxData,
  output logic [3:0] rxTag,
  output logic [1:0] rxShort,
  // transmit events
  output logic [1:0] txTake,
  output logic [1:0] txCrcDone,
  output logic [1:0] txAbortDone,
  output logic [1:0] txCloseDone
);
  // quiet lanes at time zero
  initial begin
    {rxValid, rxData, rxTag, rxShort} = '0;
    {txTake, txCrcDone, txAbortDone, txCloseDone} = '0;
  end
  // one byte delivered; data and tag lanes then show inverted values
  task automatic rx(input int ch, input [7:0] d, input [1:0] t, input s);
    @(posedge ref_clk);
    rxValid[ch] <= 1'b1;
    rxData[8*ch+:8] <= d;
    rxTag[2*ch+:2] <= t;
    rxShort[ch] <= s;
    @(posedge ref_clk);
    rxValid[ch] <= 1'b0;
    rxData[8*ch+:8] <= ~d;
    rxTag[2*ch+:2] <= ~t;
  endtask
  // event pulse: 0 take, 1 crc sent, 2 abort sent, 3 closing flag sent
  task automatic ev(input int ch, input int k);
    @(posedge ref_clk);
    case (k)
      0: txTake[ch] <= 1'b1;
      1: txCrcDone[ch] <= 1'b1;
      2: txAbortDone[ch] <= 1'b1;
      default: txCloseDone[ch] <= 1'b1;
    endcase
    @(posedge ref_clk);
    {txTake, txCrcDone, txAbortDone, txCloseDone} <= '0;
  endtask
endmodule

/* File: verif/tb.sv */
// self-checking bench for the status block with the engine model
// assumes one ref_clk domain; checker bound at the foot of this file
`timescale 1ns/1ps
`include "hss_consts.vh"
`define CHK(nm, e, s) begin n_compared++; if ((s) !== (e)) begin n_fail++; \
  $display("CHECK FAILED %s exp %0h got %0h", nm, e, s); end end
module tb;
  // bench signals
  logic ref_clk, rst_n, avs_read, avs_write, avs_waitrequest, irq;
  logic [7:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic [1:0] rxValid, rxShort, txTake, txCrcDone, txAbortDone, txCloseDone;
  logic [1:0] txLast, txFull, chanIrq;
  logic [15:0] rxData, txData;
  logic [3:0] rxTag, flagGap;
  logic [23:0] r;
  int c;
  int n_fail = 0;
  int n_compared = 0;
  // rows: status expected, channel bit 12, tag 10:9, short 8, byte 7:0
  logic [23:0] rows [4] = '{24'h8000A5, 24'h91133C, 24'hC0045A, 24'hD11781};
  hss_status u_hss_status (.ref_clk, .rst_n, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_readdata, .avs_waitrequest, .rxValid, .rxData, .rxTag, .rxShort,
    .txTake, .txCrcDone, .txAbortDone, .txCloseDone, .txData, .txLast, .txFull, .flagGap,
    .chanIrq, .irq);
  hss_eng_model u_hss_eng_model (.ref_clk, .rxValid, .rxData, .rxTag, .rxShort, .txTake,
    .txCrcDone, .txAbortDone, .txCloseDone);
  // 250 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  // verdict and stop
  task automatic end_sim;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  // one bus access held until waitrequest is seen low
  task automatic bus(input logic w, input [7:0] a, input [31:0] d);
    int n;
    @(posedge ref_clk);
    avs_read <= !w;
    avs_write <= w;
    avs_address <= a;
    avs_writedata <= d;
    for (n = 0; n < 20; n++) begin
      @(posedge ref_clk);
      if (avs_waitrequest === 1'b0) break;
    end
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (n == 20) begin
      n_fail++;
      end_sim();
    end
  endtask
  // read and compare the masked low byte
  task automatic rd(input [7:0] a, input [7:0] e, input [7:0] m, input string nm);
    bus(1'b0, a, 32'h0);
    `CHK(nm, e, q[7:0] & m)
    `CHK("upper", 24'h0, q[31:8])
  endtask
  // main sequence
  initial begin
    rst_n = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 8'h00;
    avs_writedata = 32'h0;
    tick(10);
    rst_n <= 1'b1;
    tick(1);
    `CHK("gap", 4'hA, flagGap)
    `CHK("irqs", 3'h0, {chanIrq, irq})
    rd(`HSS_IDX_INTMASK, 8'h00, 8'hFF, "mask");
    rd(8'h00, 8'h00, 8'hFF, "unmapped");
    // received byte table
    foreach (rows[i]) begin
      r = rows[i];
      c = r[12];
      u_hss_eng_model.rx(c, r[7:0], r[10:9], r[8]);
      rd(c ? `HSS_IDX_STAT1 : `HSS_IDX_STAT0, r[23:16], 8'hF1, "rxstat");
      `CHK("rxirq", 1'b1, chanIrq[c])
      rd(c ? `HSS_IDX_RXDATA1 : `HSS_IDX_RXDATA0, r[7:0], 8'hFF, "rxbyte");
      rd(c ? `HSS_IDX_STAT1 : `HSS_IDX_STAT0, 8'h00, 8'hF1, "rxempty");
      tick(2);
      `CHK("rxirqoff", 1'b0, chanIrq[c])
    end
    // overflow keeps the head and flags overrun until the read
    u_hss_eng_model.rx(0, 8'h11, 2'h0, 1'b0);
    u_hss_eng_model.rx(0, 8'h22, 2'h1, 1'b1);
    rd(`HSS_IDX_STAT0, 8'hA0, 8'hF1, "ovr");
    rd(`HSS_IDX_RXDATA0, 8'h11, 8'hFF, "head");
    rd(`HSS_IDX_STAT0, 8'h00, 8'hF1, "ovrclr");
    // interrupt raised, read-cleared, then masked off
    rd(`HSS_IDX_INTSTAT, 8'h00, 8'h00, "flush");
    bus(1'b1, `HSS_IDX_INTMASK, 32'h1);
    u_hss_eng_model.rx(0, 8'h33, 2'h0, 1'b0);
    tick(1);
    `CHK("irqon", 1'b1, irq)
    rd(`HSS_IDX_INTSTAT, 8'h01, 8'hFF, "intstat");
    tick(1);
    `CHK("irqclr", 1'b0, irq)
    rd(`HSS_IDX_RXDATA0, 8'h33, 8'hFF, "rxbyte2");
    bus(1'b1, `HSS_IDX_INTMASK, 32'h0);
    u_hss_eng_model.rx(0, 8'h44, 2'h0, 1'b0);
    tick(1);
    `CHK("masked", 1'b0, irq)
    rd(`HSS_IDX_RXDATA0, 8'h44, 8'hFF, "rxbyte3");
    // plain byte taken: request with cause 00, cleared by status write
    bus(1'b1, `HSS_IDX_TXDATA0, 32'h5A);
    rd(`HSS_IDX_STAT0, 8'h08, 8'h08, "txfull");
    u_hss_eng_model.ev(0, 0);
    tick(3);
    `CHK("takeirq", 1'b1, chanIrq[0])
    rd(`HSS_IDX_STAT0, 8'h00, 8'h0E, "cause00");
    bus(1'b1, `HSS_IDX_STAT0, 32'hFF);
    tick(2);
    `CHK("statclr", 1'b0, chanIrq[0])
    // final byte taken without a request
    bus(1'b1, `HSS_IDX_TXDATA0, 32'h1A5);
    u_hss_eng_model.ev(0, 0);
    tick(3);
    `CHK("lastquiet", 1'b0, chanIrq[0])
    // crc sent, reply gets one silent flag
    u_hss_eng_model.ev(0, 1);
    tick(3);
    `CHK("crcirq", 1'b1, chanIrq[0])
    rd(`HSS_IDX_STAT0, 8'h02, 8'h0E, "cause01");
    bus(1'b1, `HSS_IDX_TXDATA0, 32'h177);
    tick(2);
    `CHK("wrclr", 1'b0, chanIrq[0])
    `CHK("gapone", 2'h1, flagGap[1:0])
    u_hss_eng_model.ev(0, 0);
    u_hss_eng_model.ev(0, 3);
    tick(3);
    `CHK("flagquiet", 1'b0, chanIrq[0])
    // closing flag sent, reply gets two flags
    u_hss_eng_model.ev(0, 3);
    tick(3);
    `CHK("closeirq", 1'b1, chanIrq[0])
    rd(`HSS_IDX_STAT0, 8'h06, 8'h0E, "cause11");
    bus(1'b1, `HSS_IDX_TXDATA0, 32'h188);
    tick(2);
    `CHK("gaptwo", 2'h2, flagGap[1:0])
    u_hss_eng_model.ev(0, 0);
    // abort sent
    u_hss_eng_model.ev(0, 2);
    tick(3);
    `CHK("abortirq", 1'b1, chanIrq[0])
    rd(`HSS_IDX_STAT0, 8'h04, 8'h0E, "cause10");
    // flag counts, buffered byte readback, sticky causes, channel 1 paths
    rd(`HSS_IDX_GAP, 8'h0A, 8'hFF, "gapreg");
    bus(1'b0, `HSS_IDX_TXDATA0, 32'h0);
    `CHK("txback", 9'h188, q[8:0])
    u_hss_eng_model.rx(1, 8'h66, 2'h2, 1'b0);
    u_hss_eng_model.rx(1, 8'h77, 2'h0, 1'b0);
    rd(`HSS_IDX_STAT1, 8'hE0, 8'hF1, "ovr1");
    rd(`HSS_IDX_INTSTAT, 8'h9B, 8'hFF, "sticky");
    rd(`HSS_IDX_RXDATA1, 8'h66, 8'hFF, "head1");
    bus(1'b1, `HSS_IDX_TXDATA1, 32'h3C);
    u_hss_eng_model.ev(1, 0);
    tick(3);
    `CHK("takeirq1", 1'b1, chanIrq[1])
    bus(1'b1, `HSS_IDX_STAT1, 32'h0);
    tick(2);
    `CHK("statclr1", 1'b0, chanIrq[1])
    end_sim();
  end
endmodule
bind hss_status hss_checker u_hss_checker (.ref_clk, .rst_n, .avs_address, .avs_read,
  .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .rxValid, .txTake, .txCrcDone,
  .txAbortDone, .txData, .txLast, .txFull, .chanIrq);
